/* include/bst_pkg.sv */
`default_nettype none
package bst_pkg;

   // ---------------------------------------------------------------
   // geometry of the boundary chain
   // ---------------------------------------------------------------
   localparam int NUM_IOB  = 4;            // io blocks on the die
   localparam int CELLS    = 3 * NUM_IOB;  // three cells per io block
   localparam int CELL_IN  = 0;            // order inside one block
   localparam int CELL_OUT = 1;
   localparam int CELL_OE  = 2;

   // ---------------------------------------------------------------
   // instruction register
   // ---------------------------------------------------------------
   localparam int         IR_W       = 5;
   localparam logic [4:0] IR_EXTEST  = 5'h00;
   localparam logic [4:0] IR_SAMPLE  = 5'h01;
   localparam logic [4:0] IR_USER1   = 5'h02;
   localparam logic [4:0] IR_USER2   = 5'h03;
   localparam logic [4:0] IR_CFG_RD  = 5'h04;
   localparam logic [4:0] IR_CFG_WR  = 5'h05;
   localparam logic [4:0] IR_INTEST  = 5'h07;
   localparam logic [4:0] IR_UCODE   = 5'h08;
   localparam logic [4:0] IR_IDCODE  = 5'h09;
   localparam logic [4:0] IR_FLOAT   = 5'h0a;
   localparam logic [4:0] IR_STARTUP = 5'h0c;
   localparam logic [4:0] IR_BYPASS  = 5'h1f;
   localparam logic [4:0] IR_CAPTURE = 5'h01; // fixed capture pattern

   // ---------------------------------------------------------------
   // data registers and timing
   // ---------------------------------------------------------------
   localparam int          WORD_W     = 32;
   localparam logic [4:0]  WORD_LAST  = 5'h1f;          // counter value when the last bit of a word shifts in
   localparam logic [31:0] DEVICE_ID  = 32'h0a5a_5001;  // arbitrary value, lsb 1
   localparam int          SYNC_STAGES = 2;
   localparam int          REF_CLK_NS  = 100;
   localparam int          TCK_MIN_NS  = 800;
   localparam int          TCK_MIN_CYC = TCK_MIN_NS / REF_CLK_NS; // samples per tck period

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_RESET   = 4'h0, ST_IDLE    = 4'h1, ST_SEL_DR  = 4'h2, ST_CAP_DR  = 4'h3,
      ST_SH_DR   = 4'h4, ST_EX1_DR  = 4'h5, ST_PAU_DR  = 4'h6, ST_EX2_DR  = 4'h7,
      ST_UPD_DR  = 4'h8, ST_SEL_IR  = 4'h9, ST_CAP_IR  = 4'ha, ST_SH_IR   = 4'hb,
      ST_EX1_IR  = 4'hc, ST_PAU_IR  = 4'hd, ST_EX2_IR  = 4'he, ST_UPD_IR  = 4'hf
   } bst_state_t;

   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
   } bst_pins_t;

   // level of a parked controller: tck and tms high, so leaving reset makes no edge
   localparam bst_pins_t PINS_IDLE = '{tck: 1'b1, tms: 1'b1, tdi: 1'b0};

   typedef struct packed {
      logic reset;
      logic update;
      logic shift;
   } bst_strobe_t;

endpackage
`default_nettype wire

/* rtl/bst_tap.sv */
// How it works
// - decode 5-bit codes: 00000 extest, 00001 sample, 11111 bypass.
// - 00010 and 00011 put user scan register one or two in the path.
// - 00100 reads configuration back, 00101 loads configuration words.
// - 01000 shifts out the user code, 01001 the fixed device code.
// - 01010 floats every output pin and selects bypass.
// - 00111 internal test is listed but behaves as bypass.
// - public codes work always; user codes only after configuration is done.
// - every io block is a tri-state bidirectional pin in one chain.
// - each io block holds cells in, out, output enable, in that order.
// - user logic gets reset, update and shift strobes from the controller.
// - chain starts at the upper right die corner and runs round the edge.
`timescale 1ns/1ps
`default_nettype none
module bst_tap
   import bst_pkg::*;
(
   // clock and reset
   input  wire logic                 ref_clk,
   input  wire logic                 sys_rst,
   // test access pins
   input  wire bst_pins_t            tap_pins,
   output logic                      tdo_o,
   output logic                      tdo_oe,
   // io blocks: pad side and core side
   input  wire logic [NUM_IOB-1:0]   pad_in,
   output logic      [NUM_IOB-1:0]   pad_out,
   output logic      [NUM_IOB-1:0]   pad_oe,
   output logic      [NUM_IOB-1:0]   core_in,
   input  wire logic [NUM_IOB-1:0]   core_out,
   input  wire logic [NUM_IOB-1:0]   core_oe,
   // configuration side
   input  wire logic                 cfg_done,
   input  wire logic                 startup_clock_source,
   input  wire logic [WORD_W-1:0]    user_code_shift,
   input  wire logic                 cfg_rd_bit,
   output logic                      cfg_rd_shift,
   output logic      [WORD_W-1:0]    cfg_word,
   output logic                      cfg_valid,
   input  wire logic                 cfg_ready,
   output logic                      startup_step_by_tck,
   // user scan chains
   output logic                      user_scan_reg_one,
   output logic                      user_scan_reg_two,
   input  wire logic                 user_tdo_one,
   input  wire logic                 user_tdo_two,
   output logic                      user_tdi,
   output bst_strobe_t               user_strobe
);

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   bst_pins_t          pins_m_q, pins_q;
   logic               tck_prev_q;
   logic [NUM_IOB-1:0] pad_m_q, pad_q;

   // stage one feeds stage two only; edges come from stage two and its delay
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pins_m_q   <= PINS_IDLE;     // a zero here would fake a tck rise after release
         pins_q     <= PINS_IDLE;
         tck_prev_q <= PINS_IDLE.tck;
         pad_m_q    <= '0;
         pad_q      <= '0;
      end else begin
         pins_m_q   <= tap_pins;
         pins_q     <= pins_m_q;
         tck_prev_q <= pins_q.tck;
         pad_m_q    <= pad_in;
         pad_q      <= pad_m_q;
      end
   end

   logic tck_rise, tck_fall;
   assign tck_rise = pins_q.tck & ~tck_prev_q;
   assign tck_fall = ~pins_q.tck & tck_prev_q;
   assign core_in  = pad_q;

   // ---------------------------------------------------------------
   // controller and shift registers
   // ---------------------------------------------------------------
   bst_state_t         st_q, st_d;
   logic [IR_W-1:0]    ir_q, ir_d, irs_q, irs_d;
   logic [WORD_W-1:0]  dr_q, dr_d;
   logic [CELLS-1:0]   bsr_q, bsr_d, upd_q, upd_d;
   logic               byp_q, byp_d, pend_q, pend_d, step_q, step_d;
   logic [4:0]         cnt_q, cnt_d;
   logic [IR_W-1:0]    op;
   logic [CELLS-1:0]   cap;
   logic               push, buf_ready;

   // effective operation: user codes wait for configuration, intest and unused codes fall to bypass
   always_comb begin
      op = ir_q;
      case (ir_q)
         IR_EXTEST, IR_SAMPLE, IR_CFG_RD, IR_CFG_WR,
         IR_IDCODE, IR_FLOAT, IR_STARTUP, IR_BYPASS: op = ir_q;
         IR_USER1, IR_USER2, IR_UCODE: op = cfg_done ? ir_q : IR_BYPASS;
         IR_INTEST: op = IR_BYPASS;
         default:   op = IR_BYPASS;
      endcase
   end

   // block 0 sits at the upper right corner, nearest tdo; the chain runs round
   genvar g;
   generate
      for (g = 0; g < NUM_IOB; g++) begin : g_iob
         assign cap[3*g+CELL_IN]  = pad_q[g];
         assign cap[3*g+CELL_OUT] = core_out[g];
         assign cap[3*g+CELL_OE]  = core_oe[g];
         // every block acts as a tri-state bidirectional pin in extest
         assign pad_out[g] = (op == IR_EXTEST) ? upd_q[3*g+CELL_OUT] : core_out[g];
         assign pad_oe[g]  = (op == IR_FLOAT) ? 1'b0 :
                             (op == IR_EXTEST) ? upd_q[3*g+CELL_OE] : core_oe[g];
      end
   endgenerate

   // sixteen-state walk on every synchronised tck rise
   always_comb begin
      st_d   = st_q;
      ir_d   = ir_q;
      irs_d  = irs_q;
      dr_d   = dr_q;
      bsr_d  = bsr_q;
      upd_d  = upd_q;
      byp_d  = byp_q;
      cnt_d  = cnt_q;
      pend_d = pend_q & ~push;
      step_d = 1'b0;
      if (tck_rise) begin
         case (st_q)
            ST_RESET:  st_d = pins_q.tms ? ST_RESET  : ST_IDLE;
            ST_IDLE:   st_d = pins_q.tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: st_d = pins_q.tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: st_d = pins_q.tms ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR:  st_d = pins_q.tms ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: st_d = pins_q.tms ? ST_UPD_DR : ST_PAU_DR;
            ST_PAU_DR: st_d = pins_q.tms ? ST_EX2_DR : ST_PAU_DR;
            ST_EX2_DR: st_d = pins_q.tms ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: st_d = pins_q.tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: st_d = pins_q.tms ? ST_RESET  : ST_CAP_IR;
            ST_CAP_IR: st_d = pins_q.tms ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR:  st_d = pins_q.tms ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: st_d = pins_q.tms ? ST_UPD_IR : ST_PAU_IR;
            ST_PAU_IR: st_d = pins_q.tms ? ST_EX2_IR : ST_PAU_IR;
            ST_EX2_IR: st_d = pins_q.tms ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: st_d = pins_q.tms ? ST_SEL_DR : ST_IDLE;
            default:   st_d = ST_RESET;
         endcase
         case (st_q)
            ST_RESET:  ir_d = IR_IDCODE;
            ST_CAP_IR: irs_d = IR_CAPTURE;
            ST_SH_IR:  irs_d = {pins_q.tdi, irs_q[IR_W-1:1]};
            ST_UPD_IR: ir_d = irs_q;
            ST_IDLE:   step_d = (op == IR_STARTUP) & startup_clock_source;
            ST_CAP_DR: begin
               byp_d = 1'b0;
               bsr_d = cap;
               cnt_d = '0;
               if (op == IR_IDCODE) dr_d = DEVICE_ID;
               if (op == IR_UCODE)  dr_d = user_code_shift;
            end
            ST_SH_DR: begin
               byp_d = pins_q.tdi;
               bsr_d = {pins_q.tdi, bsr_q[CELLS-1:1]};
               // a word waiting on a full buffer freezes further loading
               if (op != IR_CFG_WR || !pend_q) begin
                  dr_d = {pins_q.tdi, dr_q[WORD_W-1:1]};
               end
               if (op == IR_CFG_WR && !pend_q) begin
                  cnt_d  = cnt_q + 5'h01;
                  pend_d = (cnt_q == WORD_LAST);
               end
            end
            ST_UPD_DR: if (op == IR_EXTEST || op == IR_SAMPLE) upd_d = bsr_q;
            default:   ;
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_q   <= ST_RESET;
         ir_q   <= IR_IDCODE;
         irs_q  <= '0;
         dr_q   <= '0;
         bsr_q  <= '0;
         upd_q  <= '0;
         byp_q  <= 1'b0;
         cnt_q  <= '0;
         pend_q <= 1'b0;
         step_q <= 1'b0;
      end else begin
         st_q   <= st_d;
         ir_q   <= ir_d;
         irs_q  <= irs_d;
         dr_q   <= dr_d;
         bsr_q  <= bsr_d;
         upd_q  <= upd_d;
         byp_q  <= byp_d;
         cnt_q  <= cnt_d;
         pend_q <= pend_d;
         step_q <= step_d;
      end
   end

   assign startup_step_by_tck = step_q;
   assign cfg_rd_shift      = tck_rise & (st_q == ST_SH_DR) & (op == IR_CFG_RD);
   assign user_scan_reg_one = (op == IR_USER1);
   assign user_scan_reg_two = (op == IR_USER2);
   assign user_tdi          = pins_q.tdi;
   assign user_strobe.reset  = (st_q == ST_RESET);
   assign user_strobe.update = (st_q == ST_UPD_DR);
   assign user_strobe.shift  = (st_q == ST_SH_DR);

   // ---------------------------------------------------------------
   // two-entry buffer towards the configuration bus
   // ---------------------------------------------------------------
   logic [WORD_W-1:0] buf_q [2];
   logic [WORD_W-1:0] buf_d [2];
   logic              wp_q, wp_d, rp_q, rp_d;
   logic [1:0]        fill_q, fill_d;
   logic              pop;

   assign buf_ready = (fill_q != 2'd2);
   assign push      = pend_q & buf_ready;
   assign pop       = cfg_valid & cfg_ready;
   assign cfg_valid = (fill_q != 2'd0);
   assign cfg_word  = buf_q[rp_q];

   // a stalled receiver holds the word in the shifter instead of losing it
   always_comb begin
      buf_d  = buf_q;
      wp_d   = wp_q ^ push;
      rp_d   = rp_q ^ pop;
      fill_d = fill_q + {1'b0, push} - {1'b0, pop};
      if (push) buf_d[wp_q] = dr_q;
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         buf_q[0] <= '0;
         buf_q[1] <= '0;
         wp_q     <= 1'b0;
         rp_q     <= 1'b0;
         fill_q   <= '0;
      end else begin
         buf_q    <= buf_d;
         wp_q     <= wp_d;
         rp_q     <= rp_d;
         fill_q   <= fill_d;
      end
   end

   // ---------------------------------------------------------------
   // tdo, moved on the falling tck edge
   // ---------------------------------------------------------------
   logic tdo_q, tdo_d, oe_q, oe_d, dr_bit;

   always_comb begin
      case (op)
         IR_EXTEST, IR_SAMPLE:            dr_bit = bsr_q[0];
         IR_USER1:                        dr_bit = user_tdo_one;
         IR_USER2:                        dr_bit = user_tdo_two;
         IR_CFG_RD:                       dr_bit = cfg_rd_bit;
         IR_CFG_WR, IR_UCODE, IR_IDCODE:  dr_bit = dr_q[0];
         default:                         dr_bit = byp_q;
      endcase
      tdo_d = tdo_q;
      oe_d  = oe_q;
      if (tck_fall) begin
         oe_d  = (st_q == ST_SH_DR) | (st_q == ST_SH_IR);
         tdo_d = (st_q == ST_SH_IR) ? irs_q[0] : dr_bit;
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         tdo_q <= 1'b0;
         oe_q  <= 1'b0;
      end else begin
         tdo_q <= tdo_d;
         oe_q  <= oe_d;
      end
   end

   assign tdo_o  = tdo_q;
   assign tdo_oe = oe_q;

endmodule // bst_tap
`default_nettype wire

/* sim/bst_ctl_model.sv */
`timescale 1ns/1ps
`default_nettype none
module bst_ctl_model
   import bst_pkg::*;
(
   // tap pins
   input  wire logic ref_clk,
   output bst_pins_t tap_pins,
   input  wire logic tdo_o
);
   // tck parks high between frames
   initial tap_pins = 3'b110;

   // one tck period of 8 ref_clk; tdo taken just before the rise
   task automatic tick(input logic tms, input logic tdi, output logic o);
      tap_pins.tms = tms;
      tap_pins.tdi = tdi;
      tap_pins.tck = 1'b0;
      repeat (4) @(negedge ref_clk);
      o = tdo_o;
      tap_pins.tck = 1'b1;
      repeat (4) @(negedge ref_clk);
   endtask

   // move without data; tdi flips so a stale level is never trusted
   task automatic nav(input logic tms);
      logic o;
      tick(tms, ~tap_pins.tdi, o);
   endtask

   // five tms highs reach reset, then park in idle
   task automatic tap_reset();
      repeat (5) nav(1'b1);
      nav(1'b0);
   endtask

   // idle, capture, shift n bits lsb first, update, idle
   task automatic scan(input logic ir, input int n, input logic [95:0] din,
                       output logic [95:0] dout);
      int i;
      dout = '0;
      nav(1'b1);
      if (ir) nav(1'b1);
      nav(1'b0);
      nav(1'b0);
      for (i = 0; i < n; i++) tick(i == n - 1, din[i], dout[i]);
      nav(1'b1);
      nav(1'b0);
   endtask
endmodule // bst_ctl_model
`default_nettype wire

/* sim/bst_tap_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module bst_tap_props
   import bst_pkg::*;
(
   // clock and reset
   input wire logic                ref_clk,
   input wire logic                sys_rst,
   // watched ports
   input wire bst_pins_t           tap_pins,
   input wire logic                tdo_o,
   input wire logic [NUM_IOB-1:0]  pad_in,
   input wire logic [NUM_IOB-1:0]  core_in,
   input wire logic                cfg_done,
   input wire logic                startup_clock_source,
   input wire logic [WORD_W-1:0]   cfg_word,
   input wire logic                cfg_valid,
   input wire logic                cfg_ready,
   input wire logic                startup_step_by_tck,
   input wire logic                user_scan_reg_one,
   input wire logic                user_scan_reg_two,
   input wire bst_strobe_t         user_strobe
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   a_strobe_onehot:
   assert property ($onehot0(user_strobe)) else $error("strobes overlap");
   a_tdo_on_fall:
   assert property ($changed(tdo_o) |-> !$past(tap_pins.tck, 2)) else $error("tdo moved on rise");
   a_word_holds:
   assert property (cfg_valid && !cfg_ready |=> cfg_valid && $stable(cfg_word))
      else $error("word dropped while stalled");
   a_user_gated:
   assert property (user_scan_reg_one || user_scan_reg_two |-> cfg_done)
      else $error("user chain before done");
   a_user_excl:
   assert property (!(user_scan_reg_one && user_scan_reg_two)) else $error("both chains");
   a_step_source:
   assert property (startup_step_by_tck |-> startup_clock_source) else $error("step w/o tck source");
   a_step_single:
   assert property (startup_step_by_tck |=> !startup_step_by_tck) else $error("step too long");
   a_core_follow:
   assert property ((!sys_rst && $stable(pad_in))[*5] |-> core_in == pad_in)
      else $error("core_in lags pad");
endmodule // bst_tap_props

bind bst_tap bst_tap_props u_props (.ref_clk, .sys_rst, .tap_pins, .tdo_o, .pad_in,
   .core_in, .cfg_done, .startup_clock_source, .cfg_word, .cfg_valid, .cfg_ready,
   .startup_step_by_tck, .user_scan_reg_one, .user_scan_reg_two, .user_strobe);
`default_nettype wire

/* sim/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb
   import bst_pkg::*;
;
   typedef struct packed {logic [4:0] code; logic done; logic [1:0] sel; logic [7:0] out;} bst_row_t;
   // stimulus
   logic               ref_clk = 1'b0;
   logic               sys_rst = 1'b1;
   bst_pins_t          tap_pins;
   logic [NUM_IOB-1:0] pad_in = 4'h6, core_out = 4'h5, core_oe = 4'ha;
   logic               cfg_done = 1'b0, startup_clock_source = 1'b0, cfg_rd_bit = 1'b1;
   logic               cfg_ready = 1'b0, user_tdo_one = 1'b1, user_tdo_two = 1'b0;
   logic [WORD_W-1:0]  user_code_shift = 32'h1234_5678;
   // design outputs
   logic               tdo_o, tdo_oe, cfg_rd_shift, cfg_valid, startup_step_by_tck;
   logic               user_scan_reg_one, user_scan_reg_two, user_tdi;
   logic [NUM_IOB-1:0] pad_out, pad_oe, core_in;
   logic [WORD_W-1:0]  cfg_word;
   bst_strobe_t        user_strobe;
   logic [95:0]        got, want;
   int                 errors = 0, checks_done = 0, steps = 0, rd_pulses = 0, i, r;
   // code, done, {two,one}, dr out for tdi 8'hb5; bypass gives 8'h6a
   bst_row_t rows [10] = '{
      '{5'h02, 1'b0, 2'b00, 8'h6a},
      '{5'h08, 1'b0, 2'b00, 8'h6a},
      '{5'h1f, 1'b0, 2'b00, 8'h6a},
      '{5'h07, 1'b1, 2'b00, 8'h6a},
      '{5'h0a, 1'b1, 2'b00, 8'h6a},
      '{5'h06, 1'b1, 2'b00, 8'h6a},
      '{5'h1e, 1'b1, 2'b00, 8'h6a},
      '{5'h02, 1'b1, 2'b01, 8'hff},
      '{5'h03, 1'b1, 2'b10, 8'h00},
      '{5'h04, 1'b1, 2'b00, 8'hff}};

   always #50 ref_clk = ~ref_clk;
   // start-up steps seen by the bench
   always @(posedge ref_clk) if (startup_step_by_tck) steps <= steps + 1;
   // readback shift pulses seen by the bench
   always @(posedge ref_clk) if (cfg_rd_shift) rd_pulses <= rd_pulses + 1;

   bst_tap u_bst_tap (.ref_clk, .sys_rst, .tap_pins, .tdo_o, .tdo_oe, .pad_in, .pad_out,
      .pad_oe, .core_in, .core_out, .core_oe, .cfg_done, .startup_clock_source,
      .user_code_shift, .cfg_rd_bit, .cfg_rd_shift, .cfg_word, .cfg_valid, .cfg_ready,
      .startup_step_by_tck, .user_scan_reg_one, .user_scan_reg_two, .user_tdo_one,
      .user_tdo_two, .user_tdi, .user_strobe);
   bst_ctl_model u_ctl (.ref_clk, .tap_pins, .tdo_o);

   task automatic chk(input logic [95:0] g, input logic [95:0] e, input string what);
      checks_done++;
      if (g !== e) begin
         errors++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, g, e);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // reset and id checks, table rows, then hand-written cases
   initial begin
      repeat (10) @(negedge ref_clk);
      chk(96'({tdo_oe, cfg_valid, user_strobe}), 96'h04, "reset state");
      sys_rst = 1'b0;
      repeat (3) @(negedge ref_clk);
      u_ctl.tap_reset();
      u_ctl.scan(1'b0, 32, 96'h0, got);
      chk(96'(got[31:0]), 96'(DEVICE_ID), "id after reset");
      for (r = 0; r < 10; r++) begin
         cfg_done = rows[r].done;
         u_ctl.scan(1'b1, 5, 96'(rows[r].code), got);
         chk(96'(got[4:0]), 96'h01, "ir capture");
         chk(96'({user_scan_reg_two, user_scan_reg_one}), 96'(rows[r].sel), "select");
         chk(96'(pad_oe), 96'(rows[r].code == 5'h0a ? 4'h0 : core_oe), "pad oe");
         u_ctl.scan(1'b0, 8, 96'hb5, got);
         chk(96'(got[7:0]), 96'(rows[r].out), "dr path");
      end
      // only the last row reads back: one pulse per shifted bit
      chk(96'(rd_pulses), 96'd8, "readback shifts");
      // boundary capture, then preload drives pads under extest
      pad_in = 4'h9;
      u_ctl.scan(1'b1, 5, 96'h01, got);
      u_ctl.scan(1'b0, CELLS, 96'h715, got);
      for (i = 0; i < NUM_IOB; i++)
         chk(96'(got[3*i +: 3]), 96'({core_oe[i], core_out[i], pad_in[i]}), "cells");
      chk(96'(core_in), 96'(pad_in), "core in");
      u_ctl.scan(1'b1, 5, 96'h00, got);
      chk(96'({pad_oe, pad_out}), 96'h5a, "extest pads");
      // three words with the sink stalled: two buffered, third waits in the shifter
      u_ctl.scan(1'b1, 5, 96'h05, got);
      u_ctl.scan(1'b0, 96, {32'hcccc_0003, 32'hbbbb_0002, 32'haaaa_0001}, got);
      chk(96'({cfg_valid, cfg_word}), 96'h1_aaaa_0001, "word 0");
      for (i = 0; i < 3; i++) begin
         cfg_ready = 1'b1;
         @(negedge ref_clk);
         cfg_ready = 1'b0;
         repeat (3) @(negedge ref_clk);
         want = i == 0 ? 96'h1_bbbb_0002 : i == 1 ? 96'h1_cccc_0003 : 96'h0;
         chk(i < 2 ? 96'({cfg_valid, cfg_word}) : 96'(cfg_valid), want, "pop");
      end
      u_ctl.scan(1'b1, 5, 96'h08, got);
      u_ctl.scan(1'b0, 32, 96'h0, got);
      chk(96'(got[31:0]), 96'(user_code_shift), "user code");
      // start-up stepping only with tck chosen as source
      startup_clock_source = 1'b1;
      u_ctl.scan(1'b1, 5, 96'h0c, got);
      steps = 0;
      repeat (3) u_ctl.nav(1'b0);
      startup_clock_source = 1'b0;
      repeat (3) u_ctl.nav(1'b0);
      chk(96'(steps), 96'd3, "steps");
      // mid-run reset: controller back in reset, id code loaded again
      sys_rst = 1'b1;
      repeat (2) @(negedge ref_clk);
      chk(96'({tdo_oe, cfg_valid, user_strobe}), 96'h04, "mid-run reset");
      sys_rst = 1'b0;
      repeat (3) @(negedge ref_clk);
      u_ctl.nav(1'b0);
      u_ctl.scan(1'b0, 32, 96'h0, got);
      chk(96'(got[31:0]), 96'(DEVICE_ID), "id after sys_rst");
      u_ctl.scan(1'b1, 5, 96'h1f, got);
      u_ctl.tap_reset();
      u_ctl.scan(1'b0, 32, 96'h0, got);
      chk(96'(got[31:0]), 96'(DEVICE_ID), "id after tms reset");
      print_verdict();
   end

   // hang guard, about four times the expected run
   initial begin
      repeat (20000) @(posedge ref_clk);
      errors++;
      $display("unexpected at %0t: watchdog", $time);
      print_verdict();
   end
endmodule // tb
`default_nettype wire
